// ---- gie_pkg.sv ----
package gie_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_ENABLE    = 8'h10;
  localparam logic [7:0] ADDR_SENSE     = 8'h14;
  localparam logic [7:0] ADDR_MODE      = 8'h18;
  localparam logic [7:0] ADDR_BOTH_EDGE = 8'h1C;
  localparam logic [7:0] ADDR_DEBOUNCE  = 8'h24;
  localparam logic [7:0] ADDR_DB_COUNT  = 8'h28;
  localparam logic [7:0] ADDR_EVT_STAT  = 8'h30;
  localparam logic [7:0] ADDR_EVT_CLR   = 8'h34;
  localparam logic [7:0] ADDR_EVT_EN    = 8'h38;
  localparam logic [7:0] ADDR_PIN_LEVEL = 8'h3C;
  // event status bit position and number of event bits
  localparam int EVT_PIN_IRQ = 0;
  localparam int EVT_NUM     = 1;
  // reset values and unmapped read data
  localparam logic [31:0] RST_ZERO   = 32'h0000_0000;
  localparam logic [15:0] RST_DB_CNT = 16'h0004;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage

// ---- gie_cfg_if.sv ----
`timescale 1ns/10ps
interface gie_cfg_if #(parameter int NPIN = 9, parameter int CW = 16);
  logic [NPIN-1:0] enable;
  logic [NPIN-1:0] sense;
  logic [NPIN-1:0] mode;
  logic [NPIN-1:0] both_edge;
  logic [NPIN-1:0] debounce;
  logic [CW-1:0]   db_count;
  logic [NPIN-1:0] trigger;
  logic [NPIN-1:0] level;
  modport ctl (output enable, sense, mode, both_edge, debounce, db_count, input trigger, level);
  modport det (input enable, sense, mode, both_edge, debounce, db_count, output trigger, level);
endinterface

// ---- gie_detect.sv ----
`timescale 1ns/10ps
module gie_detect #(
  parameter int NPIN = 9,
  parameter int CW   = 16
) (
  // clock and reset
  input  wire logic    i_ref_clk,
  input  wire logic    i_reset,
  input  wire logic    i_ce,
  // pins
  input  wire logic [NPIN-1:0] i_pin,
  // configuration and triggers
  gie_cfg_if.det       cfg
);
  typedef struct packed {
    logic [NPIN-1:0]         s1;
    logic [NPIN-1:0]         s2;
    logic [NPIN-1:0]         s3;
    logic [NPIN-1:0]         filt;
    logic [NPIN-1:0]         prev;
    logic [NPIN-1:0][CW-1:0] cnt;
  } gie_det_t;

  gie_det_t st;
  gie_det_t next_st;

  logic [NPIN-1:0] active;

  always_comb begin
    next_st = st;
    active  = '0;
    next_st.s1 = i_pin;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.prev = st.filt;
    for (int n = 0; n < NPIN; n++) begin
      if (!cfg.debounce[n]) begin
        if (st.s2[n] == st.s3[n]) begin
          next_st.filt[n] = st.s3[n];
        end
        next_st.cnt[n] = '0;
      end else if (st.s3[n] == st.filt[n] || st.s2[n] != st.s3[n]) begin
        next_st.cnt[n] = '0;
      end else if (st.cnt[n] >= cfg.db_count) begin
        next_st.filt[n] = st.s3[n];
        next_st.cnt[n]  = '0;
      end else begin
        next_st.cnt[n] = st.cnt[n] + CW'(1);
      end
      if (!cfg.mode[n]) begin
        active[n] = st.filt[n] ^ cfg.sense[n];
      end else if (cfg.both_edge[n]) begin
        active[n] = st.filt[n] ^ st.prev[n];
      end else begin
        active[n] = (st.filt[n] ^ st.prev[n]) & (st.filt[n] ^ cfg.sense[n]);
      end
    end
  end

  assign cfg.trigger = active & cfg.enable;
  assign cfg.level   = st.filt;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      // idle pins are low, so a zero reset avoids a false edge
      st <= '0;
    end else if (i_ce) begin
      st <= next_st;
    end
  end
endmodule

// ---- gie_top.sv ----
// Implementation choice: register access over Wishbone.
`timescale 1ns/10ps
module gie_top #(
  parameter int NPIN = 9,
  parameter int CW   = 16
) (
  // clock, reset, enable
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset,
  input  wire logic        i_ce,
  // wishbone slave
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  // pins and interrupt
  input  wire logic [NPIN-1:0] i_pin,
  output logic             o_irq
);
  // the register map has 32-bit words and a 16-bit debounce count
  if (NPIN < 1 || NPIN > 32 || CW < 1 || CW > 16) begin : g_param_check
    $error("gie_top: unsupported parameters");
  end

  typedef struct packed {
    logic [NPIN-1:0] enable;
    logic [NPIN-1:0] sense;
    logic [NPIN-1:0] mode;
    logic [NPIN-1:0] both_edge;
    logic [NPIN-1:0] debounce;
    logic [CW-1:0]   db_count;
    logic [gie_pkg::EVT_NUM-1:0] evt_stat;
    logic [gie_pkg::EVT_NUM-1:0] evt_en;
    logic [31:0]     rdata;
    logic            ack;
    logic            irq;
  } gie_regs_t;

  gie_regs_t r;
  gie_regs_t next_r;

  gie_cfg_if #(.NPIN(NPIN), .CW(CW)) cfg ();

  gie_detect #(.NPIN(NPIN), .CW(CW)) u_detect (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_ce      (i_ce),
    .i_pin     (i_pin),
    .cfg       (cfg.det)
  );

  assign cfg.enable    = r.enable;
  assign cfg.sense     = r.sense;
  assign cfg.mode      = r.mode;
  assign cfg.both_edge = r.both_edge;
  assign cfg.debounce  = r.debounce;
  assign cfg.db_count  = r.db_count;

  logic        req;
  logic [31:0] wmask;
  logic [31:0] wval;

  // byte-lane merge of write data into a register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] m,
                                        input logic [31:0] d);
    merge = (old & ~m) | (d & m);
  endfunction

  always_comb begin
    next_r = r;
    req    = i_wb_cyc && i_wb_stb && !r.ack;
    wmask  = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
    wval   = gie_pkg::RST_ZERO;
    next_r.ack = req;
    // reserved bits above NPIN are dropped; software is expected to write them zero
    if (req && i_wb_we) begin
      case (i_wb_adr)
        gie_pkg::ADDR_ENABLE: begin
          wval = merge(32'(r.enable), wmask, i_wb_dat);
          next_r.enable = wval[NPIN-1:0];
        end
        gie_pkg::ADDR_SENSE: begin
          wval = merge(32'(r.sense), wmask, i_wb_dat);
          next_r.sense = wval[NPIN-1:0];
        end
        gie_pkg::ADDR_MODE: begin
          wval = merge(32'(r.mode), wmask, i_wb_dat);
          next_r.mode = wval[NPIN-1:0];
        end
        gie_pkg::ADDR_BOTH_EDGE: begin
          wval = merge(32'(r.both_edge), wmask, i_wb_dat);
          next_r.both_edge = wval[NPIN-1:0];
        end
        gie_pkg::ADDR_DEBOUNCE: begin
          wval = merge(32'(r.debounce), wmask, i_wb_dat);
          next_r.debounce = wval[NPIN-1:0];
        end
        gie_pkg::ADDR_DB_COUNT: begin
          wval = merge(32'(r.db_count), wmask, i_wb_dat);
          next_r.db_count = wval[CW-1:0];
        end
        gie_pkg::ADDR_EVT_EN: begin
          wval = merge(32'(r.evt_en), wmask, i_wb_dat);
          next_r.evt_en = wval[gie_pkg::EVT_NUM-1:0];
        end
        gie_pkg::ADDR_EVT_CLR: begin
          if (i_wb_sel[0]) begin
            next_r.evt_stat = r.evt_stat & ~i_wb_dat[gie_pkg::EVT_NUM-1:0];
          end
        end
        default: begin
          wval = gie_pkg::RST_ZERO;
        end
      endcase
    end
    // set wins over a same-cycle clear
    if (|cfg.trigger) begin
      next_r.evt_stat[gie_pkg::EVT_PIN_IRQ] = 1'b1;
    end
    next_r.rdata = gie_pkg::UNMAPPED_DATA;
    if (req && !i_wb_we) begin
      case (i_wb_adr)
        gie_pkg::ADDR_ENABLE:    next_r.rdata = 32'(r.enable);
        gie_pkg::ADDR_SENSE:     next_r.rdata = 32'(r.sense);
        gie_pkg::ADDR_MODE:      next_r.rdata = 32'(r.mode);
        gie_pkg::ADDR_BOTH_EDGE: next_r.rdata = 32'(r.both_edge);
        gie_pkg::ADDR_DEBOUNCE:  next_r.rdata = 32'(r.debounce);
        gie_pkg::ADDR_DB_COUNT:  next_r.rdata = 32'(r.db_count);
        gie_pkg::ADDR_EVT_STAT:  next_r.rdata = 32'(r.evt_stat);
        gie_pkg::ADDR_EVT_EN:    next_r.rdata = 32'(r.evt_en);
        gie_pkg::ADDR_PIN_LEVEL: next_r.rdata = 32'(cfg.level);
        default:                 next_r.rdata = gie_pkg::UNMAPPED_DATA;
      endcase
    end
    next_r.irq = |(next_r.evt_stat & next_r.evt_en);
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      r          <= '0;
      r.db_count <= gie_pkg::RST_DB_CNT[CW-1:0];
    end else if (i_ce) begin
      r <= next_r;
    end
  end

  assign o_wb_dat = r.rdata;
  assign o_wb_ack = r.ack;
  assign o_irq    = r.irq;
endmodule

// ---- gie_props.sv ----
`timescale 1ns/10ps
module gie_props #(parameter int NPIN = 9, parameter int CW = 16) (
  // clock, reset, bus
  input logic            i_ref_clk,
  input logic            i_reset,
  input logic            i_ce,
  input logic            i_wb_cyc,
  input logic            i_wb_stb,
  input logic            i_wb_we,
  input logic [7:0]      i_wb_adr,
  input logic [3:0]      i_wb_sel,
  input logic [31:0]     i_wb_dat,
  input logic [31:0]     o_wb_dat,
  input logic            o_wb_ack,
  // pins and interrupt
  input logic [NPIN-1:0] i_pin,
  input logic            o_irq
);
  logic [8:0] en_sh;
  logic       req;
  logic       off;
  assign req = i_wb_cyc && i_wb_stb && i_ce && !o_wb_ack;
  assign off = en_sh == 9'h000;
  // shadow of the pin enables, lets the disabled-pin checks see the config
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      en_sh <= 9'h000;
    end else if (req && i_wb_we && i_wb_adr == 8'h10) begin
      en_sh <= i_wb_dat[8:0];
    end
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  property p_ack; req |=> o_wb_ack; endproperty
  property p_pulse; o_wb_ack && i_ce |=> !o_wb_ack; endproperty
  property p_idle; !o_wb_ack |-> o_wb_dat == 32'h0000_0000; endproperty
  property p_rst; $fell(i_reset) |-> !o_wb_ack && !o_irq; endproperty
  property p_resv;
    req && !i_wb_we && i_wb_adr inside {8'h10, 8'h14} |=> o_wb_dat[31:9] == 23'h0;
  endproperty
  property p_unm; req && !i_wb_we && i_wb_adr < 8'h10 |=> o_wb_dat == 32'h0; endproperty
  property p_dis; off && $past(off) && !o_irq && !i_wb_cyc |=> !o_irq; endproperty
  property p_clr;
    req && i_wb_we && i_wb_adr == 8'h34 && i_wb_sel[0] && i_wb_dat[0] && off && $past(off)
      |-> ##[1:3] !o_irq;
  endproperty
  a_ack: assert property (p_ack) else $error("request not answered next cycle");
  a_pulse: assert property (p_pulse) else $error("ack longer than one cycle");
  a_idle: assert property (p_idle) else $error("read data not zero outside ack");
  a_rst: assert property (p_rst) else $error("outputs active after reset");
  a_resv: assert property (p_resv) else $error("reserved bits read nonzero");
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  a_dis: assert property (p_dis) else $error("irq from disabled pins");
  a_clr: assert property (p_clr) else $error("irq stuck after clear");
  c_read: cover property (o_wb_ack && !i_wb_we);
  c_rise: cover property ($rose(o_irq));
  c_fall: cover property ($fell(o_irq));
endmodule

// ---- gie_host_model.sv ----
`timescale 1ns/10ps
module gie_host_model (
  // clock and answer
  input  wire logic        i_ref_clk,
  input  wire logic        i_ack,
  input  wire logic [31:0] i_dat,
  // request
  output logic             o_cyc,
  output logic             o_we,
  output logic [7:0]       o_adr,
  output logic [31:0]      o_dat
);
  initial begin
    o_cyc = 1'b0;
    o_we  = 1'b0;
    o_adr = 8'h00;
    o_dat = 32'h0000_0000;
  end
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge i_ref_clk);
    o_cyc <= 1'b1;
    o_we  <= w;
    o_adr <= a;
    // reserved bits zero; every field used here fits in 9 bits
    o_dat <= d & 32'h0000_01FF;
    @(posedge i_ref_clk);
    while (i_ack !== 1'b1) @(posedge i_ref_clk);
    q = i_dat;
    o_cyc <= 1'b0;
    o_we  <= 1'b0;
    // released lines show garbage so a stale value cannot pass
    o_adr <= ~a;
    o_dat <= ~o_dat;
  endtask
endmodule

// ---- tb_gpio_irq_enable_sense.sv ----
`timescale 1ns/10ps
module tb_gpio_irq_enable_sense;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [8:0]  pin = 9'h000;
  logic        cyc, we, ack, irq;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, q;
  int          errors = 0;
  int          n_compared = 0;
  int          ticks = 0;
  always #25 clk = ~clk;
  gie_top #(.NPIN(9), .CW(16)) gie_top_inst (.i_ref_clk(clk), .i_reset(rst), .i_ce(1'b1),
    .i_wb_cyc(cyc), .i_wb_stb(cyc), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF),
    .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_pin(pin), .o_irq(irq));
  gie_host_model gie_host_model_inst (.i_ref_clk(clk), .i_ack(ack), .i_dat(rdat),
    .o_cyc(cyc), .o_we(we), .o_adr(adr), .o_dat(wdat));
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    gie_host_model_inst.acc(1'b1, a, d, q);
  endtask
  task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
    gie_host_model_inst.acc(1'b0, a, 32'h0, q);
    n_compared++;
    if (q !== exp) begin
      errors++;
      $display("MISMATCH reg %h expected %h seen %h", a, exp, q);
    end
  endtask
  task automatic chk_irq(input logic [8:0] p, input logic exp);
    #1;
    n_compared++;
    if (irq !== exp) begin
      errors++;
      $display("MISMATCH irq pins %h expected %b seen %b", p, exp, irq);
    end
  endtask
  // clear the event first, then move the pins and judge the irq level
  task automatic probe(input logic [8:0] p, input logic exp);
    wr(8'h34, 32'h1);
    repeat (8) @(posedge clk);
    pin <= p;
    repeat (8) @(posedge clk);
    chk_irq(p, exp);
  endtask
  // debounce on pin 0 in level mode, default count of four
  task automatic t_debounce;
    wr(8'h1C, 32'h0);
    wr(8'h18, 32'h0);
    wr(8'h14, 32'h0);
    wr(8'h10, 32'h1);
    wr(8'h24, 32'h1);
    wr(8'h38, 32'h1);
    wr(8'h34, 32'h1);
    @(posedge clk);
    pin <= 9'h101;
    repeat (2) @(posedge clk);
    pin <= 9'h100;
    repeat (16) @(posedge clk);
    chk_irq(9'h101, 1'b0);
    pin <= 9'h101;
    repeat (16) @(posedge clk);
    chk_irq(9'h101, 1'b1);
    chk_reg(8'h30, 32'h1);
    chk_reg(8'h3C, 32'h101);
    wr(8'h38, 32'h0);
    chk_irq(9'h101, 1'b0);
    chk_reg(8'h30, 32'h1);
    $display("test debounce done");
  endtask
  task automatic t_regs;
    chk_reg(8'h10, 32'h0);
    chk_reg(8'h14, 32'h0);
    wr(8'h10, 32'h155);
    wr(8'h14, 32'h0AA);
    wr(8'h04, 32'h1FF);
    chk_reg(8'h10, 32'h155);
    chk_reg(8'h14, 32'h0AA);
    chk_reg(8'h04, 32'h0);
    $display("test registers done");
  endtask
  task automatic t_level;
    wr(8'h38, 32'h1);
    wr(8'h18, 32'h0);
    wr(8'h14, 32'h0);
    wr(8'h10, 32'h1);
    probe(9'h001, 1'b1);
    wr(8'h14, 32'h1);
    probe(9'h000, 1'b1);
    $display("test level done");
  endtask
  task automatic t_edge;
    wr(8'h18, 32'h1);
    probe(9'h001, 1'b0);
    probe(9'h000, 1'b1);
    wr(8'h14, 32'h0);
    probe(9'h001, 1'b1);
    probe(9'h000, 1'b0);
    wr(8'h1C, 32'h1);
    probe(9'h001, 1'b1);
    probe(9'h000, 1'b1);
    $display("test edge done");
  endtask
  task automatic t_disable;
    wr(8'h10, 32'h0);
    probe(9'h001, 1'b0);
    wr(8'h10, 32'h100);
    probe(9'h000, 1'b0);
    probe(9'h100, 1'b1);
    $display("test disable done");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_level;
    t_edge;
    t_disable;
    t_debounce;
    print_verdict;
  end
  always @(posedge clk) begin
    ticks++;
    if (ticks == 4000) begin
      errors++;
      print_verdict;
    end
  end
endmodule
bind gie_top gie_props #(.NPIN(NPIN), .CW(CW)) gie_props_inst (.i_ref_clk(i_ref_clk),
  .i_reset(i_reset), .i_ce(i_ce), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
  .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
  .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_pin(i_pin), .o_irq(o_irq));
